// file: design/scd_clock_select.sv
// Top of the system clock source select and divider block
//
// Operation
// - Divide field divides source by 1 to 128
// - New divisor applied within 128 source cycles
// - Bit 7 ready: 0 pending, 1 applied
// - Source switch effective after slower oscillator period
// - Source codes 000,001,011,100; others reserved
// - Bit 3 reads zero; software writes zero
// - Register at address A9 on every page
//
// Ticks stand in for oscillator edges; the core clock must run
// faster than every source, or edges are lost.
// Reserved source codes read back but never steer the clock.
// Divisor swaps wait for the counter wrap, so no short period appears.
// Ticks arriving while CE is low are lost; the sources do not pause with it.
`timescale 1ns/1ps
module scd_clock_select (
  input wire logic CLOCK, // Core clock, 25 MHz
  input wire logic RST, // Async reset, high
  input wire logic CE, // Clock enable, freezes state when low
  input wire logic [7:0] SFR_ADDR, // Register address
  input wire logic SFR_WR, // Write strobe
  input wire logic SFR_RD, // Read strobe
  input wire logic [7:0] SFR_WDATA, // Write data
  output logic [7:0] SFR_RDATA, // Read data, one cycle after strobe
  input wire logic PRECISION_TICK, // Precision internal oscillator edge
  input wire logic EXTERNAL_TICK, // External oscillator edge
  input wire logic RTC_TICK, // Real-time-clock oscillator edge
  input wire logic LOWPOWER_TICK, // Low-power oscillator edge
  output logic SYSCLK_TICK, // Divided system clock edge
  output logic [2:0] SOURCE_ACTIVE, // Source code now in use
  output logic SOURCE_SWITCHING // Source change in progress
);
  scd_div_if dif ();

  logic [scd_pkg::DIV_W-1:0] divide_select;
  logic [scd_pkg::DIV_W-1:0] next_divide_select;
  logic [scd_pkg::SRC_W-1:0] source_select;
  logic [scd_pkg::SRC_W-1:0] next_source_select;
  logic [scd_pkg::SRC_W-1:0] active_src;
  logic [scd_pkg::SRC_W-1:0] next_active_src;
  logic [scd_pkg::SRC_W-1:0] target_src;
  logic [scd_pkg::SRC_W-1:0] next_target_src;
  scd_pkg::scd_swap_state_t state;
  scd_pkg::scd_swap_state_t next_state;
  logic seen_old;
  logic next_seen_old;
  logic seen_new;
  logic next_seen_new;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic load;
  logic next_load;
  logic hit;
  logic wr_hit;
  logic old_tick;
  logic new_tick;
  logic [7:0] reg_value;

  // ----------------------------------------------------------------
  // Oscillator tick selection
  // ----------------------------------------------------------------
  function automatic logic pick_tick(input logic [scd_pkg::SRC_W-1:0] code,
                                     input logic p, input logic e,
                                     input logic r, input logic l);
    case (code)
      scd_pkg::SRC_PRECISION: pick_tick = p;
      scd_pkg::SRC_EXTERNAL: pick_tick = e;
      scd_pkg::SRC_RTC: pick_tick = r;
      scd_pkg::SRC_LOWPOWER: pick_tick = l;
      default: pick_tick = 1'b0;
    endcase
  endfunction

  function automatic logic src_valid(input logic [scd_pkg::SRC_W-1:0] code);
    case (code)
      scd_pkg::SRC_PRECISION,
      scd_pkg::SRC_EXTERNAL,
      scd_pkg::SRC_RTC,
      scd_pkg::SRC_LOWPOWER: src_valid = 1'b1;
      default: src_valid = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb begin
    // No page decode at all, so the register answers on every page
    hit = (SFR_ADDR == scd_pkg::SEL_ADDR);
    wr_hit = SFR_WR && hit;
    reg_value = 8'h00;
    reg_value[scd_pkg::READY_BIT] = dif.ready;
    reg_value[scd_pkg::DIV_MSB:scd_pkg::DIV_LSB] = divide_select;
    reg_value[scd_pkg::SRC_MSB:scd_pkg::SRC_LSB] = source_select;
    // Idle read data is zero, so a shared read bus can simply OR sources
    if (SFR_RD && hit) begin
      next_rdata = reg_value;
    end else begin
      next_rdata = 8'h00;
    end
    next_divide_select = divide_select;
    next_source_select = source_select;
    next_load = 1'b0;
    if (wr_hit) begin
      // Written bit 3 and bit 7 are dropped
      next_divide_select = SFR_WDATA[scd_pkg::DIV_MSB:scd_pkg::DIV_LSB];
      next_source_select = SFR_WDATA[scd_pkg::SRC_MSB:scd_pkg::SRC_LSB];
      next_load = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      divide_select <= scd_pkg::DIV_RESET;
      source_select <= scd_pkg::SRC_RESET;
      rdata <= 8'h00;
      load <= 1'b0;
    end else if (CE) begin
      divide_select <= next_divide_select;
      source_select <= next_source_select;
      rdata <= next_rdata;
      load <= next_load;
    end
  end

  // ----------------------------------------------------------------
  // On-the-fly source switch
  // ----------------------------------------------------------------
  always_comb begin
    old_tick = pick_tick(active_src, PRECISION_TICK, EXTERNAL_TICK,
                         RTC_TICK, LOWPOWER_TICK);
    new_tick = pick_tick(target_src, PRECISION_TICK, EXTERNAL_TICK,
                         RTC_TICK, LOWPOWER_TICK);
    next_state = state;
    next_active_src = active_src;
    next_target_src = target_src;
    next_seen_old = seen_old;
    next_seen_new = seen_new;
    case (state)
      scd_pkg::SW_RUN: begin
        next_seen_old = 1'b0;
        next_seen_new = 1'b0;
      end
      scd_pkg::SW_SWAP: begin
        // One edge of each oscillator spans a full period of the slower one
        if ((seen_old || old_tick) && (seen_new || new_tick)) begin
          next_active_src = target_src;
          next_state = scd_pkg::SW_RUN;
        end else begin
          next_seen_old = seen_old || old_tick;
          next_seen_new = seen_new || new_tick;
        end
      end
      default: next_state = scd_pkg::SW_RUN;
    endcase
    // Reserved codes are stored but never steer the clock
    if (load && src_valid(source_select)) begin
      next_target_src = source_select;
      next_seen_old = 1'b0;
      next_seen_new = 1'b0;
      next_state = (source_select == active_src) ? scd_pkg::SW_RUN : scd_pkg::SW_SWAP;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= scd_pkg::SW_RUN;
      active_src <= scd_pkg::SRC_RESET;
      target_src <= scd_pkg::SRC_RESET;
      seen_old <= 1'b0;
      seen_new <= 1'b0;
    end else if (CE) begin
      state <= next_state;
      active_src <= next_active_src;
      target_src <= next_target_src;
      seen_old <= next_seen_old;
      seen_new <= next_seen_new;
    end
  end

  // ----------------------------------------------------------------
  // Divider and outputs
  // ----------------------------------------------------------------
  // Undivided tick keeps the old source until the swap completes
  assign dif.tick = old_tick;
  assign dif.load = load;
  assign dif.div_code = divide_select;

  scd_divider u_div (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .dv(dif.div)
  );

  assign SFR_RDATA = rdata;
  assign SYSCLK_TICK = dif.sys_tick;
  assign SOURCE_ACTIVE = active_src;
  assign SOURCE_SWITCHING = (state == scd_pkg::SW_SWAP);
endmodule // scd_clock_select

// file: design/scd_pkg.sv
// Shared constants for the system clock select and divider block
package scd_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_ADDR = 8'hA9;
  localparam int READY_BIT = 7;
  localparam int DIV_LSB = 4;
  localparam int DIV_MSB = 6;
  localparam int UNUSED_BIT = 3;
  localparam int SRC_LSB = 0;
  localparam int SRC_MSB = 2;
  // ----------------------------------------------------------------
  // Field widths, codes and reset values
  // ----------------------------------------------------------------
  localparam int DIV_W = 3;
  localparam int SRC_W = 3;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;
  localparam logic [DIV_W-1:0] DIV_RESET = 3'h3;
  localparam logic [SRC_W-1:0] SRC_PRECISION = 3'h0;
  localparam logic [SRC_W-1:0] SRC_EXTERNAL = 3'h1;
  localparam logic [SRC_W-1:0] SRC_RTC = 3'h3;
  localparam logic [SRC_W-1:0] SRC_LOWPOWER = 3'h4;
  localparam logic [SRC_W-1:0] SRC_RESET = SRC_LOWPOWER;
  localparam logic READY_RESET = 1'b0;
  // ----------------------------------------------------------------
  // Source switch states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SW_RUN = 2'b01,
    SW_SWAP = 2'b10
  } scd_swap_state_t;
endpackage

// file: design/scd_div_if.sv
// Carrier between the clock select logic and the divider
`timescale 1ns/1ps
interface scd_div_if;
  logic tick;
  logic load;
  logic [scd_pkg::DIV_W-1:0] div_code;
  logic sys_tick;
  logic ready;
  modport ctrl (output tick, output load, output div_code, input sys_tick, input ready);
  modport div (input tick, input load, input div_code, output sys_tick, output ready);
endinterface

// file: design/scd_divider.sv
// Power-of-two divider of the undivided source tick stream
`timescale 1ns/1ps
module scd_divider (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  scd_div_if.div dv // Tick in, divided tick and ready out
);
  logic [scd_pkg::CNT_W-1:0] cnt;
  logic [scd_pkg::CNT_W-1:0] next_cnt;
  logic [scd_pkg::DIV_W-1:0] cur_div;
  logic [scd_pkg::DIV_W-1:0] next_cur_div;
  logic [scd_pkg::DIV_W-1:0] pend_div;
  logic [scd_pkg::DIV_W-1:0] next_pend_div;
  logic pending;
  logic next_pending;
  logic sys_tick;
  logic next_sys_tick;
  logic [scd_pkg::CNT_W-1:0] mask;
  logic boundary;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    mask = scd_pkg::CNT_W'(~(8'hFF << cur_div));
    boundary = dv.tick && (cnt == scd_pkg::CNT_MAX);
    next_cnt = dv.tick ? cnt + 7'h01 : cnt;
    next_sys_tick = dv.tick && ((cnt & mask) == mask);
    next_cur_div = cur_div;
    next_pend_div = pend_div;
    next_pending = pending;
    // Swap only where every divisor is phase aligned, so no short pulse
    if (boundary && pending) begin
      next_cur_div = pend_div;
      next_pending = 1'b0;
    end
    // A fresh write wins: it is not yet applied even if a swap just happened
    if (dv.load) begin
      next_pend_div = dv.div_code;
      next_pending = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 7'h00;
      cur_div <= scd_pkg::DIV_RESET;
      pend_div <= scd_pkg::DIV_RESET;
      pending <= 1'b1;
      sys_tick <= 1'b0;
    end else if (ce) begin
      cnt <= next_cnt;
      cur_div <= next_cur_div;
      pend_div <= next_pend_div;
      pending <= next_pending;
      sys_tick <= next_sys_tick;
    end
  end

  assign dv.sys_tick = sys_tick;
  assign dv.ready = ~pending;
endmodule // scd_divider

// file: sim/scd_clock_select_props.sv
// Checker for register reads and source switching of the clock select block
`timescale 1ns/1ps
module scd_clock_select_props (
  input wire logic CLOCK, // Core clock
  input wire logic RST, // Async reset
  input wire logic CE, // Clock enable
  input wire logic [7:0] SFR_ADDR, // Address
  input wire logic SFR_WR, // Write strobe
  input wire logic SFR_RD, // Read strobe
  input wire logic [7:0] SFR_WDATA, // Write data
  input wire logic [7:0] SFR_RDATA, // Read data
  input wire logic PRECISION_TICK, // Source tick
  input wire logic EXTERNAL_TICK, // Source tick
  input wire logic RTC_TICK, // Source tick
  input wire logic LOWPOWER_TICK, // Source tick
  input wire logic SYSCLK_TICK, // Divided tick
  input wire logic [2:0] SOURCE_ACTIVE, // Source in use
  input wire logic SOURCE_SWITCHING // Swap waiting
);
  logic [2:0] sh_div, sh_src, next_div, next_src;
  logic [2:0] sh_tgt, next_tgt;
  wire any_tick = PRECISION_TICK | EXTERNAL_TICK | RTC_TICK | LOWPOWER_TICK;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence wr_hit; CE && SFR_WR && SFR_ADDR == scd_pkg::SEL_ADDR; endsequence
  sequence rd_hit; CE && SFR_RD && SFR_ADDR == scd_pkg::SEL_ADDR; endsequence
  // Shadow of the written fields, so reads can be judged without the body
  always_comb begin
    next_div = sh_div;
    next_src = sh_src;
    next_tgt = sh_tgt;
    if (CE && SFR_WR && SFR_ADDR == scd_pkg::SEL_ADDR) begin
      next_div = SFR_WDATA[6:4];
      next_src = SFR_WDATA[2:0];
      // Only legal codes can become the swap target
      if (SFR_WDATA[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4}) next_tgt = SFR_WDATA[2:0];
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sh_div <= scd_pkg::DIV_RESET;
      sh_src <= scd_pkg::SRC_RESET;
      sh_tgt <= scd_pkg::SRC_RESET;
    end else begin
      sh_div <= next_div;
      sh_src <= next_src;
      sh_tgt <= next_tgt;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_miss_reads_zero: assert property (
    CE && SFR_RD && SFR_ADDR != scd_pkg::SEL_ADDR |=> SFR_RDATA == 8'h00)
    else $error("Unmapped read returned data");
  chk_idle_reads_zero: assert property (CE && !SFR_RD |=> SFR_RDATA == 8'h00)
    else $error("Read data without a read");
  chk_bit3_reads_zero: assert property (rd_hit |=> !SFR_RDATA[3])
    else $error("Unused bit read as one");
  chk_fields_read_back: assert property (
    rd_hit |=> SFR_RDATA[6:0] == {$past(sh_div), 1'b0, $past(sh_src)})
    else $error("Divide or source field read back wrong");
  chk_ready_pending: assert property (wr_hit ##2 rd_hit |=> !SFR_RDATA[7])
    else $error("Ready still set after a new divide write");
  chk_source_legal: assert property (
    SOURCE_ACTIVE inside {3'h0, 3'h1, 3'h3, 3'h4})
    else $error("Reserved source in use");
  chk_switch_to_written: assert property (
    $changed(SOURCE_ACTIVE) |-> SOURCE_ACTIVE == $past(sh_tgt) || SOURCE_ACTIVE == $past(sh_tgt, 2))
    else $error("Source changed to an unwritten code");
  chk_reserved_no_swap: assert property (
    wr_hit ##0 (!SOURCE_SWITCHING && !(SFR_WDATA[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4}))
    |=> (!SOURCE_SWITCHING) [*2])
    else $error("Reserved code started a swap");
  chk_tick_from_source: assert property (
    SYSCLK_TICK |-> $past(any_tick) || $past(any_tick, 2))
    else $error("Divided tick without a source tick");
endmodule // scd_clock_select_props
bind scd_clock_select scd_clock_select_props u_props (.CLOCK(CLOCK), .RST(RST), .CE(CE),
  .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
  .SFR_RDATA(SFR_RDATA), .PRECISION_TICK(PRECISION_TICK), .EXTERNAL_TICK(EXTERNAL_TICK),
  .RTC_TICK(RTC_TICK), .LOWPOWER_TICK(LOWPOWER_TICK), .SYSCLK_TICK(SYSCLK_TICK),
  .SOURCE_ACTIVE(SOURCE_ACTIVE), .SOURCE_SWITCHING(SOURCE_SWITCHING));

// file: sim/system_clock_select_divider_tb_top.sv
// Self-checking bench for the clock select and divider block
`timescale 1ns/1ps
module system_clock_select_divider_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic tick_rand = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [3:0] ticks = 4'h0; // Precision, external, rtc, lowpower
  logic [7:0] sfr_rdata, q, a;
  logic sysclk_tick, source_switching;
  logic [2:0] source_active, exp_div, exp_src, exp_act;
  logic [31:0] r;
  integer seed = 32'h6950534B;
  int err_total = 0;
  int checks_done = 0;
  int n;
  scd_clock_select DUT (.CLOCK(clock), .RST(rst), .CE(1'b1), .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
    .PRECISION_TICK(ticks[3]), .EXTERNAL_TICK(ticks[2]), .RTC_TICK(ticks[1]),
    .LOWPOWER_TICK(ticks[0]), .SYSCLK_TICK(sysclk_tick), .SOURCE_ACTIVE(source_active),
    .SOURCE_SWITCHING(source_switching));
  always #20 clock = ~clock;
  always @(posedge clock) if (tick_rand) ticks <= 4'($random(seed));
  function automatic logic [7:0] exp_rd(input logic [7:0] ad);
    return (ad == scd_pkg::SEL_ADDR) ? {1'b0, exp_div, 1'b0, exp_src} : 8'h00;
  endfunction
  // Zero marks a reserved code
  function automatic logic [3:0] tick_of(input logic [2:0] c);
    case (c)
      scd_pkg::SRC_PRECISION: return 4'h8;
      scd_pkg::SRC_EXTERNAL: return 4'h4;
      scd_pkg::SRC_RTC: return 4'h2;
      scd_pkg::SRC_LOWPOWER: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
    if (ad == scd_pkg::SEL_ADDR) {exp_div, exp_src} = {d[6:4], d[2:0]};
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clock);
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1 q = sfr_rdata;
  endtask
  task automatic pulse(input logic [3:0] t);
    @(posedge clock);
    ticks <= t;
    @(posedge clock);
    ticks <= 4'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #800000;
    err_total++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {exp_div, exp_src, exp_act} = {scd_pkg::DIV_RESET, scd_pkg::SRC_RESET, scd_pkg::SRC_RESET};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    ticks <= 4'h1;
    rd(scd_pkg::SEL_ADDR);
    chk(q, 8'h34);
    // Low-power source ticks every cycle, so a window of 128 cycles is exact
    for (int d = 0; d < 8; d++) begin
      wr(scd_pkg::SEL_ADDR, {1'b0, 3'(d), 1'b0, scd_pkg::SRC_LOWPOWER});
      rd(scd_pkg::SEL_ADDR);
      chk({7'h00, q[7]}, 8'h00);
      for (n = 0; q[7] !== 1'b1 && n < 66; n++) rd(scd_pkg::SEL_ADDR);
      chk({7'h00, q[7]}, 8'h01);
      n = 0;
      repeat (128) begin
        @(posedge clock);
        #1 if (sysclk_tick === 1'b1) n++;
      end
      chk(8'(n), 8'(128 >> d));
    end
    for (int c = 0; c < 8; c++) begin
      wr(scd_pkg::SEL_ADDR, {5'h00, 3'(c)});
      pulse(tick_of(exp_act));
      chk({5'h00, source_active}, {5'h00, exp_act});
      chk({7'h00, source_switching},
          {7'h00, (tick_of(3'(c)) != 4'h0) && (3'(c) != exp_act)});
      pulse(4'hF);
      if (tick_of(3'(c)) != 4'h0) exp_act = 3'(c);
      chk({5'h00, source_active}, {5'h00, exp_act});
      chk({7'h00, source_switching}, 8'h00);
    end
    tick_rand <= 1'b1;
    repeat (300) begin
      r = $random(seed);
      a = r[1] ? scd_pkg::SEL_ADDR : r[15:8];
      if (r[0]) wr(a, r[23:16] & 8'hF7);
      else begin
        rd(a);
        chk(q & ((a == scd_pkg::SEL_ADDR) ? 8'h7F : 8'hFF), exp_rd(a));
      end
    end
    // Divide-by-1 before the low-power entry that the reset stands for
    wr(scd_pkg::SEL_ADDR, {1'b0, 3'h0, 1'b0, scd_pkg::SRC_LOWPOWER});
    // Flash read-time bypass lives outside this block
    @(posedge clock) rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    {exp_div, exp_src} = {scd_pkg::DIV_RESET, scd_pkg::SRC_RESET};
    rd(scd_pkg::SEL_ADDR);
    chk(q, 8'h34);
    chk({5'h00, source_active}, {5'h00, scd_pkg::SRC_RESET});
    print_verdict();
  end
endmodule // system_clock_select_divider_tb_top
